// File: hw/edge_catch.sv
`timescale 1ns/1ps
module edge_catch (
  edge_if.catcher e
);

  // Clocked by the line itself so a pulse far shorter than clk is kept
  always_ff @(posedge e.src or posedge e.clr) begin
    if (e.clr) begin
      e.rise_tgl <= 1'b0;
    end else begin
      e.rise_tgl <= ~e.rise_tgl;
    end
  end

  // Separate flop on the other edge; a both-edge pulse toggles both
  always_ff @(negedge e.src or posedge e.clr) begin
    if (e.clr) begin
      e.fall_tgl <= 1'b0;
    end else begin
      e.fall_tgl <= ~e.fall_tgl;
    end
  end

endmodule

// File: hw/edge_if.sv
`timescale 1ns/1ps
interface edge_if;
  logic src;
  logic clr;
  logic rise_tgl;
  logic fall_tgl;
  modport catcher (input src, input clr, output rise_tgl, output fall_tgl);
  modport ctrl (output src, output clr, input rise_tgl, input fall_tgl);
endinterface

// File: hw/ext_event_ctrl.sv
`timescale 1ns/1ps
module ext_event_ctrl #(
  parameter int NUM_PINS = 16
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [NUM_PINS-1:0] gpio_i,
  input wire logic svd_i,
  input wire logic [1:0] cmp_i,
  input wire logic rtc_wake_i,
  input wire logic tick_wake_i,
  output logic [20:0] line_irq_o,
  output logic irq_o,
  output logic wake_o
);

  localparam int NL = ext_event_pkg::NUM_LINES;
  localparam int PL = ext_event_pkg::PIN_LINES;
  localparam int SW = ext_event_pkg::SEL_W;
  localparam int SPW = ext_event_pkg::SEL_PER_WORD;

  // Select field is four bits, so more pins cannot be reached
  initial begin
    if (NUM_PINS < 1 || NUM_PINS > 16) begin
      $error("NUM_PINS must lie between 1 and 16");
    end
  end

  logic [20:0] mask;
  logic [20:0] rise_en;
  logic [20:0] fall_en;
  logic [20:0] pending;
  logic [20:0] next_pending;
  logic [SW-1:0] sel [PL];
  logic [20:0] rise_raw;
  logic [20:0] fall_raw;
  logic [20:0] rise_s1;
  logic [20:0] rise_s2;
  logic [20:0] rise_s3;
  logic [20:0] fall_s1;
  logic [20:0] fall_s2;
  logic [20:0] fall_s3;
  logic [20:0] rise_seen;
  logic [20:0] fall_seen;
  logic [20:0] rise_eff;
  logic [20:0] fall_eff;
  logic [20:0] new_ev;
  logic [20:0] clr_bits;
  logic [20:0] src_line;
  logic [11:0] dp_addr;
  logic wr_pend;
  logic rd_pend;
  logic accept;
  logic [31:0] rd_word;

  // Out-of-range selects read a quiet low rather than a stray pin
  function automatic logic pick_pin(input logic [NUM_PINS-1:0] pins,
                                    input logic [SW-1:0] idx);
    logic v;
    v = 1'b0;
    if (int'(idx) < NUM_PINS) begin
      v = pins[idx];
    end
    return v;
  endfunction

  // Source routing for every line
  always_comb begin
    src_line = '0;
    for (int i = 0; i < PL; i++) begin
      src_line[i] = pick_pin(gpio_i, sel[i]);
    end
    src_line[ext_event_pkg::SVD_LINE] = svd_i;
    src_line[ext_event_pkg::CMP0_LINE] = cmp_i[0];
    src_line[ext_event_pkg::CMP1_LINE] = cmp_i[1];
    src_line[ext_event_pkg::RTC_LINE] = rtc_wake_i;
    src_line[ext_event_pkg::TICK_LINE] = tick_wake_i;
  end

  // One asynchronous catcher per line
  generate
    for (genvar g = 0; g < NL; g++) begin : g_line
      edge_if e ();
      assign e.src = src_line[g];
      assign e.clr = reset_i;
      assign rise_raw[g] = e.rise_tgl;
      assign fall_raw[g] = e.fall_tgl;
      edge_catch u_catch (
        .e(e.catcher)
      );
    end
  endgenerate

  // Toggles cross into clk by two flops; third flop gives the change
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rise_s1 <= '0;
      rise_s2 <= '0;
      rise_s3 <= '0;
      fall_s1 <= '0;
      fall_s2 <= '0;
      fall_s3 <= '0;
    end else begin
      rise_s1 <= rise_raw;
      rise_s2 <= rise_s1;
      rise_s3 <= rise_s2;
      fall_s1 <= fall_raw;
      fall_s2 <= fall_s1;
      fall_s3 <= fall_s2;
    end
  end

  assign rise_seen = rise_s2 ^ rise_s3;
  assign fall_seen = fall_s2 ^ fall_s3;

  // Timer wake lines are pinned to rising edge whatever software writes
  assign rise_eff = rise_en | ext_event_pkg::FIXED_RISE;
  assign fall_eff = fall_en & ~ext_event_pkg::FIXED_RISE;

  // Edge choice and mask decide what becomes an event
  assign new_ev = ((rise_seen & rise_eff) | (fall_seen & fall_eff))
                  & mask;

  // Bus address phase is taken only for whole-word transfers
  assign accept = hsel_i && hready_i
                  && htrans_i == ext_event_pkg::HTRANS_NONSEQ
                  && hsize_i == ext_event_pkg::HSIZE_WORD;

  // Data phase bookkeeping; frozen while a read wait holds the bus
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dp_addr <= 12'h000;
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
    end else begin
      if (hready_i) begin
        dp_addr <= haddr_i[11:0];
        wr_pend <= accept && hwrite_i;
        rd_pend <= accept && !hwrite_i;
      end
    end
  end

  // Reads wait one cycle so a write just before is already in place
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      hreadyout_o <= 1'b1;
      hrdata_o <= 32'h00000000;
    end else if (accept && !hwrite_i) begin
      hreadyout_o <= 1'b0;
    end else if (rd_pend && !hreadyout_o) begin
      hreadyout_o <= 1'b1;
      hrdata_o <= rd_word;
    end else begin
      hreadyout_o <= 1'b1;
    end
  end

  // Never an error response
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      hresp_o <= 1'b0;
    end else begin
      hresp_o <= 1'b0;
    end
  end

  // Read decode; unmapped offsets read zero
  always_comb begin
    rd_word = 32'h00000000;
    if (dp_addr == ext_event_pkg::MASK_OFS) begin
      rd_word[20:0] = mask;
    end else if (dp_addr == ext_event_pkg::RISE_OFS) begin
      rd_word[20:0] = rise_en;
    end else if (dp_addr == ext_event_pkg::FALL_OFS) begin
      rd_word[20:0] = fall_en;
    end else if (dp_addr == ext_event_pkg::PEND_OFS) begin
      rd_word[20:0] = pending;
    end else if (dp_addr == ext_event_pkg::SEL0_OFS) begin
      for (int i = 0; i < SPW; i++) begin
        rd_word[i*SW +: SW] = sel[i];
      end
    end else if (dp_addr == ext_event_pkg::SEL1_OFS) begin
      for (int i = 0; i < SPW; i++) begin
        rd_word[i*SW +: SW] = sel[i+SPW];
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mask <= ext_event_pkg::MASK_RST;
      rise_en <= ext_event_pkg::RISE_RST;
      fall_en <= ext_event_pkg::FALL_RST;
    end else if (wr_pend) begin
      if (dp_addr == ext_event_pkg::MASK_OFS) begin
        mask <= hwdata_i[20:0];
      end else if (dp_addr == ext_event_pkg::RISE_OFS) begin
        rise_en <= hwdata_i[20:0];
      end else if (dp_addr == ext_event_pkg::FALL_OFS) begin
        fall_en <= hwdata_i[20:0];
      end
    end
  end

  // Source select fields
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < PL; i++) begin
        sel[i] <= ext_event_pkg::SEL_RST;
      end
    end else if (wr_pend) begin
      if (dp_addr == ext_event_pkg::SEL0_OFS) begin
        for (int i = 0; i < SPW; i++) begin
          sel[i] <= hwdata_i[i*SW +: SW];
        end
      end else if (dp_addr == ext_event_pkg::SEL1_OFS) begin
        for (int i = 0; i < SPW; i++) begin
          sel[i+SPW] <= hwdata_i[i*SW +: SW];
        end
      end
    end
  end

  // Write one to clear; a fresh event in the same cycle wins
  assign clr_bits = (wr_pend && dp_addr == ext_event_pkg::PEND_OFS)
                    ? hwdata_i[20:0] : 21'h000000;
  assign next_pending = (pending & ~clr_bits) | new_ev;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pending <= 21'h000000;
    end else begin
      pending <= next_pending;
    end
  end

  // Requests to the processor; registered, so one cycle behind pending
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      line_irq_o <= 21'h000000;
      irq_o <= 1'b0;
    end else begin
      line_irq_o <= pending & mask;
      irq_o <= |(pending & mask);
    end
  end

  // Wake pulse; needs clk running, the catchers hold the edge meanwhile
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= |new_ev;
    end
  end

  // Checks
  AST_PEND_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
    (pending & $past(pending & ~clr_bits)) ==
    $past(pending & ~clr_bits))
    else $error("pending bit dropped without a clear");

  AST_PEND_SET: assert property (@(posedge clk_i) disable iff (reset_i)
    |new_ev |=> (pending & $past(new_ev)) == $past(new_ev))
    else $error("event not latched");

  AST_MASK_NOFWD: assert property (@(posedge clk_i) disable iff (reset_i)
    (line_irq_o & ~$past(mask)) == 21'h000000)
    else $error("masked line forwarded a request");

  AST_EV_MASKED: assert property (@(posedge clk_i) disable iff (reset_i)
    (new_ev & ~mask) == 21'h000000)
    else $error("masked line produced an event");

  AST_EV_TO_WAKE: assert property (@(posedge clk_i) disable iff (reset_i)
    |new_ev |=> wake_o)
    else $error("event without wake pulse");

  AST_WAKE_CAUSE: assert property (@(posedge clk_i) disable iff (reset_i)
    wake_o |-> $past(|new_ev))
    else $error("wake pulse without cause");

  AST_EDGE_SEL: assert property (@(posedge clk_i) disable iff (reset_i)
    (new_ev & ~((rise_seen & rise_en) | (fall_seen & fall_en)
     | (rise_seen & ext_event_pkg::FIXED_RISE))) == 21'h000000)
    else $error("event on a disabled edge");

  AST_TIMER_RISE: assert property (@(posedge clk_i) disable iff (reset_i)
    (new_ev & ext_event_pkg::FIXED_RISE & ~rise_seen) == 21'h000000)
    else $error("timer wake line fired on a falling edge");

  AST_IRQ_LEVEL: assert property (@(posedge clk_i) disable iff (reset_i)
    (|(pending & mask)) ##1 (|(pending & mask)) |-> irq_o)
    else $error("interrupt low while unmasked pending");

  AST_SVD_LINE: assert property (@(posedge clk_i) disable iff (reset_i)
    $changed(rise_s2[ext_event_pkg::SVD_LINE])
    && mask[ext_event_pkg::SVD_LINE] && rise_en[ext_event_pkg::SVD_LINE]
    |=> pending[ext_event_pkg::SVD_LINE])
    else $error("supply detector edge lost");

  AST_SYNC_LAT: assert property (@(posedge clk_i) disable iff (reset_i)
    $changed(rise_s2[0]) && mask[0] && rise_en[0]
    |=> pending[0])
    else $error("caught edge did not reach pending");

endmodule

// File: hw/ext_event_pkg.sv
package ext_event_pkg;

  // Line map: pins first, then the fixed internal sources
  localparam int NUM_LINES = 21;
  localparam int PIN_LINES = 16;
  localparam int SVD_LINE = 16;
  localparam int CMP0_LINE = 17;
  localparam int CMP1_LINE = 18;
  localparam int RTC_LINE = 19;
  localparam int TICK_LINE = 20;

  // Source select fields: one nibble per pin line, eight to a word
  localparam int SEL_W = 4;
  localparam int SEL_PER_WORD = 8;

  // Register byte offsets
  localparam logic [11:0] MASK_OFS = 12'h000;
  localparam logic [11:0] RISE_OFS = 12'h004;
  localparam logic [11:0] FALL_OFS = 12'h008;
  localparam logic [11:0] PEND_OFS = 12'h00C;
  localparam logic [11:0] SEL0_OFS = 12'h010;
  localparam logic [11:0] SEL1_OFS = 12'h014;

  // Reset values
  localparam logic [20:0] MASK_RST = 21'h000000;
  localparam logic [20:0] RISE_RST = 21'h000000;
  localparam logic [20:0] FALL_RST = 21'h000000;
  localparam logic [3:0] SEL_RST = 4'h0;

  // Timer wake lines trigger on rising edge only
  localparam logic [20:0] FIXED_RISE = 21'h180000;

  // Bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage

// File: verif/ext_event_ctrl_tb.sv
`timescale 1ns/1ps
module ext_event_ctrl_tb;
  logic clk_i, reset_i, hsel, hwrite, hrdy, hresp, svd, rtc, tick, irq, wake;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, cmp;
  logic [2:0] hsize;
  logic [15:0] gpio;
  logic [20:0] line_irq;
  int bad_count, cmp_count, wake_cnt, exp_wake;
  logic [31:0] exp_q[$];
  string nam_q[$];
  logic rdy_q;

  ext_event_ctrl DUT (.clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .gpio_i(gpio), .svd_i(svd),
    .cmp_i(cmp), .rtc_wake_i(rtc), .tick_wake_i(tick),
    .line_irq_o(line_irq), .irq_o(irq), .wake_o(wake));
  wake_sink sink (.clk_i(clk_i), .reset_i(reset_i), .wake_i(wake),
    .wake_cnt_o(wake_cnt));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string w, input logic [31:0] e, logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, s);
    end
  endtask

  // Read data lands while ready climbs back; oldest note is due then
  always @(negedge clk_i) begin
    if (rdy_q === 1'b0 && hrdy === 1'b1 && exp_q.size() > 0)
      chk(nam_q.pop_front(), exp_q.pop_front(), hrdata);
    rdy_q = hrdy;
  end

  // One single word transfer; waits on ready, never a fixed count
  task automatic bus(input logic wr, input logic [11:0] a, logic [31:0] d);
    htrans <= ext_event_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {20'h00000, a};
    do @(posedge clk_i); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (hrdy !== 1'b1);
  endtask

  task automatic rd(input logic [11:0] a, logic [31:0] e, string w);
    exp_q.push_back(e);
    nam_q.push_back(w);
    bus(1'b0, a, 32'h00000000);
  endtask

  task automatic set_src(input int ln, int pin, logic v);
    if (ln < 16) gpio[pin] <= v;
    else if (ln == 16) svd <= v;
    else if (ln < 19) cmp[ln-17] <= v;
    else if (ln == 19) rtc <= v;
    else tick <= v;
  endtask

  // Drive one source level, then look at pending, request and wake
  task automatic ev(input int ln, int pin, logic v, logic hit);
    logic [31:0] b;
    b = 32'h00000001 << ln;
    set_src(ln, pin, v);
    repeat (6) @(posedge clk_i);
    if (hit) exp_wake++;
    rd(ext_event_pkg::PEND_OFS, hit ? b : 32'h0, "pending");
    chk("irq", {31'h0, hit}, {31'h0, irq});
    chk("line irq", hit ? b : 32'h0, {11'h000, line_irq});
    chk("wakes", exp_wake, wake_cnt);
    bus(1'b1, ext_event_pkg::PEND_OFS, b);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask

  initial begin
    int pin;
    logic [31:0] r, b;
    {reset_i, hsel, hsize} = {1'b1, 1'b1, ext_event_pkg::HSIZE_WORD};
    {hwrite, haddr, hwdata, htrans, svd, rtc, tick, cmp, gpio} = '0;
    void'($urandom(93937));
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    // Reset values, including unmapped words past the map
    for (int a = 0; a < 9; a++) rd(12'(a * 4), 32'h0, "reset value");
    chk("resp", 32'h0, {31'h0, hresp});
    $display("Test reset values done");
    for (int a = 0; a < 6; a++) begin
      r = $urandom;
      bus(1'b1, 12'(a * 4), r);
      rd(12'(a * 4), a < 3 ? r & 32'h001FFFFF : (a == 3 ? 32'h0 : r),
         "readback");
    end
    $display("Test register access done");
    // Every line in rise, fall and both edge modes, steps up then down
    bus(1'b1, ext_event_pkg::MASK_OFS, 32'h001FFFFF);
    for (int ln = 0; ln < 21; ln++) begin
      for (int m = 1; m < 4; m++) begin
        pin = $urandom % 16;
        b = 32'h00000001 << ln;
        r = 32'(pin) << (4 * (ln % 8));
        if (ln < 16) bus(1'b1, ln < 8 ? 12'h010 : 12'h014, r);
        bus(1'b1, ext_event_pkg::RISE_OFS, m[0] ? b : 32'h0);
        bus(1'b1, ext_event_pkg::FALL_OFS, m[1] ? b : 32'h0);
        ev(ln, pin, 1'b1, ln > 18 || m[0]);
        ev(ln, pin, 1'b0, ln < 19 && m[1]);
      end
    end
    $display("Test edge modes done");
    // Glitch far shorter than a clock still caught
    bus(1'b1, ext_event_pkg::SEL0_OFS, 32'h00007000);
    bus(1'b1, ext_event_pkg::RISE_OFS, 32'h00000008);
    bus(1'b1, ext_event_pkg::FALL_OFS, 32'h00000000);
    #4 gpio[7] = 1'b1;
    #5 gpio[7] = 1'b0;
    ev(3, 7, 1'b0, 1'b1);
    $display("Test narrow pulse done");
    // Masked edge leaves nothing behind once unmasked
    bus(1'b1, ext_event_pkg::SEL0_OFS, 32'h00200000);
    bus(1'b1, ext_event_pkg::RISE_OFS, 32'h00000020);
    bus(1'b1, ext_event_pkg::MASK_OFS, 32'h001FFFDF);
    ev(5, 2, 1'b1, 1'b0);
    bus(1'b1, ext_event_pkg::MASK_OFS, 32'h001FFFFF);
    ev(5, 2, 1'b0, 1'b0);
    ev(5, 2, 1'b1, 1'b1);
    $display("Test mask done");
    complete_run();
  end

  // Hang guard, well past the expected run length
  initial begin
    #200000;
    bad_count++;
    complete_run();
  end
endmodule

// File: verif/wake_sink.sv
`timescale 1ns/1ps
module wake_sink (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic wake_i,
  output int wake_cnt_o
);
  // Power logic counts one exit from stop per wake pulse
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wake_cnt_o <= 0;
    end else if (wake_i) begin
      wake_cnt_o <= wake_cnt_o + 1;
    end
  end
endmodule
